// [hw/flash_command_decoder.sv]
`timescale 1ns/10ps
`default_nettype none

module flash_command_decoder (
    input  wire logic                                 mclk,
    input  wire logic                                 reset_n,
    input  wire logic                                 we_valid,
    input  wire logic [flash_cmd_pkg::ADDR_W-1:0]     we_addr,
    input  wire logic [flash_cmd_pkg::DATA_W-1:0]     we_data,
    output logic                                      we_ready,
    input  wire logic                                 wsm_busy,
    input  wire logic                                 wsm_done,
    input  wire logic                                 wsm_prog_fail,
    input  wire logic                                 wsm_erase_fail,
    output logic                                      op_valid,
    input  wire logic                                 op_ready,
    output logic [2:0]                                op_kind,
    output logic [flash_cmd_pkg::ADDR_W-1:0]          op_addr,
    output logic [flash_cmd_pkg::DATA_W-1:0]          op_data,
    output logic                                      suspend_req,
    output logic                                      resume_req,
    output logic [1:0]                                read_mode,
    output logic [7:0]                                status_word
);

    // ************************************************************
    // Decoder states
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE, ST_PROG_SETUP, ST_BUF_COUNT, ST_BUF_DATA, ST_BUF_CONFIRM,
        ST_FACT_SETUP, ST_FACT_MODE, ST_ERASE_SETUP, ST_PROG_RUN, ST_ERASE_RUN,
        ST_PROG_SUSP, ST_ERASE_SUSP
    } state_t;

    state_t                           state_reg, state_next;       // Command sequence position
    flash_cmd_pkg::read_mode_t        mode_reg, mode_next;         // Current read mode
    logic [7:0]                       status_reg, status_next;     // Status word image
    logic [flash_cmd_pkg::COUNT_W-1:0] left_reg, left_next;        // Buffer words still to load, less one
    logic                             susp_reg, susp_next;         // Suspend request pulse
    logic                             resume_reg, resume_next;     // Resume request pulse
    logic                             push;                        // Place one operation in buffer
    logic [2:0]                       push_kind;                   // Kind of pushed operation
    logic                             accept;                      // Host write taken this cycle
    logic [7:0]                       cmd;                         // Command byte of the write

    // Matches either word program setup code
    function automatic logic is_word_setup(input logic [7:0] c);
        is_word_setup = (c == flash_cmd_pkg::CODE_WORD_PROG) || (c == flash_cmd_pkg::CODE_WORD_PROG_ALT);
    endfunction : is_word_setup

    assign cmd    = we_data[7:0];
    assign accept = we_valid && we_ready;

    // ************************************************************
    // Command sequencing
    // ************************************************************
    // Next state, read mode, status and buffer pushes
    always_comb begin
        state_next  = state_reg;
        mode_next   = mode_reg;
        status_next = status_reg;
        left_next   = left_reg;
        susp_next   = 1'b0;
        resume_next = 1'b0;
        push        = 1'b0;
        push_kind   = flash_cmd_pkg::OP_WORD;
        if (accept) begin
            case (state_reg)
                ST_IDLE, ST_PROG_SUSP, ST_ERASE_SUSP: begin
                    // Mode and status commands are taken at any address
                    if (cmd == flash_cmd_pkg::CODE_READ_ARRAY) begin
                        mode_next = flash_cmd_pkg::MODE_ARRAY;
                    end else if (cmd == flash_cmd_pkg::CODE_READ_STATUS) begin
                        mode_next = flash_cmd_pkg::MODE_STATUS;
                    end else if (cmd == flash_cmd_pkg::CODE_READ_QUERY) begin
                        mode_next = flash_cmd_pkg::MODE_QUERY;
                    end else if (cmd == flash_cmd_pkg::CODE_CLEAR_STATUS) begin
                        status_next[flash_cmd_pkg::BIT_ERASE_ERR] = 1'b0;
                        status_next[flash_cmd_pkg::BIT_PROG_ERR]  = 1'b0;
                    end else if (state_reg == ST_PROG_SUSP && cmd == flash_cmd_pkg::CODE_CONFIRM) begin
                        state_next  = ST_PROG_RUN;
                        resume_next = 1'b1;
                        status_next[flash_cmd_pkg::BIT_PROG_SUSP] = 1'b0;
                    end else if (state_reg == ST_ERASE_SUSP && cmd == flash_cmd_pkg::CODE_CONFIRM) begin
                        state_next  = ST_ERASE_RUN;
                        resume_next = 1'b1;
                        status_next[flash_cmd_pkg::BIT_ERASE_SUSP] = 1'b0;
                    end else if (state_reg == ST_IDLE) begin
                        // Setup codes only start from a quiet machine
                        if (is_word_setup(cmd)) begin
                            state_next = ST_PROG_SETUP;
                        end else if (cmd == flash_cmd_pkg::CODE_BUF_PROG) begin
                            state_next = ST_BUF_COUNT;
                        end else if (cmd == flash_cmd_pkg::CODE_FACTORY_PROG) begin
                            state_next = ST_FACT_SETUP;
                        end else if (cmd == flash_cmd_pkg::CODE_ERASE) begin
                            state_next = ST_ERASE_SETUP;
                        end
                    end
                end
                ST_PROG_SETUP: begin
                    // Second cycle carries the word itself
                    push       = 1'b1;
                    push_kind  = flash_cmd_pkg::OP_WORD;
                    state_next = ST_PROG_RUN;
                    mode_next  = flash_cmd_pkg::MODE_STATUS;
                end
                ST_BUF_COUNT: begin
                    // A count above the capacity is a sequence error
                    mode_next = flash_cmd_pkg::MODE_STATUS;
                    if (we_data > {11'h000, flash_cmd_pkg::BUF_MAX_M1}) begin
                        state_next = ST_IDLE;
                        status_next[flash_cmd_pkg::BIT_ERASE_ERR] = 1'b1;
                        status_next[flash_cmd_pkg::BIT_PROG_ERR]  = 1'b1;
                    end else begin
                        left_next  = we_data[flash_cmd_pkg::COUNT_W-1:0];
                        state_next = ST_BUF_DATA;
                    end
                end
                ST_BUF_DATA: begin
                    push      = 1'b1;
                    push_kind = flash_cmd_pkg::OP_BUF_WORD;
                    if (left_reg == 5'h00) begin
                        state_next = ST_BUF_CONFIRM;
                    end else begin
                        left_next = left_reg - 5'h01;
                    end
                end
                ST_BUF_CONFIRM: begin
                    if (cmd == flash_cmd_pkg::CODE_CONFIRM) begin
                        push       = 1'b1;
                        push_kind  = flash_cmd_pkg::OP_BUF_CONFIRM;
                        state_next = ST_PROG_RUN;
                    end else begin
                        // Missing confirm flags a sequence error
                        state_next = ST_IDLE;
                        status_next[flash_cmd_pkg::BIT_ERASE_ERR] = 1'b1;
                        status_next[flash_cmd_pkg::BIT_PROG_ERR]  = 1'b1;
                    end
                end
                ST_FACT_SETUP: begin
                    mode_next = flash_cmd_pkg::MODE_STATUS;
                    if (cmd == flash_cmd_pkg::CODE_CONFIRM) begin
                        push       = 1'b1;
                        push_kind  = flash_cmd_pkg::OP_FACTORY;
                        state_next = ST_FACT_MODE;
                    end else begin
                        state_next = ST_IDLE;
                        status_next[flash_cmd_pkg::BIT_ERASE_ERR] = 1'b1;
                        status_next[flash_cmd_pkg::BIT_PROG_ERR]  = 1'b1;
                    end
                end
                ST_FACT_MODE: begin
                    // Every write is data; no command is decoded here
                    push      = 1'b1;
                    push_kind = flash_cmd_pkg::OP_FACTORY_WORD;
                end
                ST_ERASE_SETUP: begin
                    mode_next = flash_cmd_pkg::MODE_STATUS;
                    if (cmd == flash_cmd_pkg::CODE_CONFIRM) begin
                        push       = 1'b1;
                        push_kind  = flash_cmd_pkg::OP_ERASE;
                        state_next = ST_ERASE_RUN;
                    end else begin
                        state_next = ST_IDLE;
                        status_next[flash_cmd_pkg::BIT_ERASE_ERR] = 1'b1;
                        status_next[flash_cmd_pkg::BIT_PROG_ERR]  = 1'b1;
                    end
                end
                ST_PROG_RUN, ST_ERASE_RUN: begin
                    // Only read-status and suspend pass while busy
                    if (cmd == flash_cmd_pkg::CODE_READ_STATUS) begin
                        mode_next = flash_cmd_pkg::MODE_STATUS;
                    end else if (cmd == flash_cmd_pkg::CODE_SUSPEND) begin
                        susp_next = 1'b1;
                        if (state_reg == ST_PROG_RUN) begin
                            state_next = ST_PROG_SUSP;
                            status_next[flash_cmd_pkg::BIT_PROG_SUSP] = 1'b1;
                        end else begin
                            state_next = ST_ERASE_SUSP;
                            status_next[flash_cmd_pkg::BIT_ERASE_SUSP] = 1'b1;
                        end
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end
        // Completion ends a running or factory operation
        if (wsm_done && (state_reg == ST_PROG_RUN || state_reg == ST_ERASE_RUN || state_reg == ST_FACT_MODE)) begin
            state_next = ST_IDLE;
        end
        // Hardware failures set error bits; a set beats a same-cycle clear
        if (wsm_erase_fail) begin
            status_next[flash_cmd_pkg::BIT_ERASE_ERR] = 1'b1;
        end
        if (wsm_prog_fail) begin
            status_next[flash_cmd_pkg::BIT_PROG_ERR] = 1'b1;
        end
        // Ready while nothing runs; a suspended machine also reads ready
        status_next[flash_cmd_pkg::BIT_READY] = !wsm_busy &&
            (state_next != ST_PROG_RUN) && (state_next != ST_ERASE_RUN) && (state_next != ST_FACT_MODE);
    end

    // Register the sequencing state
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg  <= ST_IDLE;
            mode_reg   <= flash_cmd_pkg::MODE_ARRAY;
            status_reg <= flash_cmd_pkg::STATUS_RESET;
            left_reg   <= '0;
            susp_reg   <= 1'b0;
            resume_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            mode_reg   <= mode_next;
            status_reg <= status_next;
            left_reg   <= left_next;
            susp_reg   <= susp_next;
            resume_reg <= resume_next;
        end
    end

    assign suspend_req = susp_reg;
    assign resume_req  = resume_reg;
    assign read_mode   = mode_reg;
    assign status_word = status_reg;

    // ************************************************************
    // Two-entry operation buffer
    // ************************************************************
    localparam int ENTRY_W = 3 + flash_cmd_pkg::ADDR_W + flash_cmd_pkg::DATA_W;

    logic [ENTRY_W-1:0] mem_reg [flash_cmd_pkg::DEPTH];   // Buffered operations
    logic [ENTRY_W-1:0] mem_next [flash_cmd_pkg::DEPTH];
    logic               wr_ptr_reg, wr_ptr_next;          // Slot for next push
    logic               rd_ptr_reg, rd_ptr_next;          // Slot at the head
    logic [1:0]         count_reg, count_next;            // Occupied slots
    logic               pop;                              // Head taken by write state machine

    // Stall the host whenever no slot is free, so no word is lost
    assign we_ready = (count_reg != 2'd2);
    assign op_valid = (count_reg != 2'd0);
    assign pop      = op_valid && op_ready;
    assign op_kind  = mem_reg[rd_ptr_reg][ENTRY_W-1 -: 3];
    assign op_addr  = mem_reg[rd_ptr_reg][flash_cmd_pkg::ADDR_W+flash_cmd_pkg::DATA_W-1 -: flash_cmd_pkg::ADDR_W];
    assign op_data  = mem_reg[rd_ptr_reg][flash_cmd_pkg::DATA_W-1:0];

    // Pointer and occupancy update
    always_comb begin
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = {push_kind, we_addr, we_data};
            wr_ptr_next          = !wr_ptr_reg;
        end
        if (pop) begin
            rd_ptr_next = !rd_ptr_reg;
        end
        if (push && !pop) begin
            count_next = count_reg + 2'd1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'd1;
        end
    end

    // Register the buffer
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'd0;
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
            mem_reg    <= mem_next;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence erase_bad_confirm;
        accept && state_reg == ST_ERASE_SETUP && cmd != flash_cmd_pkg::CODE_CONFIRM;
    endsequence
    a_query_mode: assert property (accept && state_reg == ST_IDLE && cmd == flash_cmd_pkg::CODE_READ_QUERY
        |=> read_mode == flash_cmd_pkg::MODE_QUERY) else $error("query code did not select query mode");
    a_error_clear: assert property ($fell(status_word[flash_cmd_pkg::BIT_PROG_ERR])
        |-> $past(accept && cmd == flash_cmd_pkg::CODE_CLEAR_STATUS)) else $error("error bit cleared unasked");
    a_word_latch: assert property (accept && state_reg == ST_PROG_SETUP
        |=> state_reg == ST_PROG_RUN && op_valid) else $error("word program not latched");
    a_prog_filter: assert property (accept && state_reg == ST_PROG_RUN && !wsm_done
        && cmd != flash_cmd_pkg::CODE_SUSPEND |=> state_reg == ST_PROG_RUN) else $error("busy command taken");
    a_alt_code: assert property (accept && state_reg == ST_IDLE && cmd == flash_cmd_pkg::CODE_WORD_PROG_ALT
        |=> state_reg == ST_PROG_SETUP) else $error("alternate program code not decoded");
    a_buf_cap: assert property (accept && state_reg == ST_BUF_COUNT && |we_data[15:5]
        |=> state_reg == ST_IDLE && status_word[5] && status_word[4]) else $error("oversize count not refused");
    a_erase_error: assert property (erase_bad_confirm |=> state_reg == ST_IDLE
        && status_word[5] && status_word[4] && read_mode == flash_cmd_pkg::MODE_STATUS)
        else $error("bad erase confirm not flagged");
    a_erase_filter: assert property (accept && state_reg == ST_ERASE_RUN && !wsm_done
        && cmd != flash_cmd_pkg::CODE_SUSPEND |=> state_reg == ST_ERASE_RUN) else $error("erase command taken");
    a_suspend_flag: assert property (accept && state_reg == ST_PROG_RUN && cmd == flash_cmd_pkg::CODE_SUSPEND
        && !wsm_done |=> suspend_req && status_word[2] ##1 !suspend_req) else $error("program suspend not shown");
    a_suspend_hold: assert property (state_reg == ST_ERASE_SUSP
        && !(accept && cmd == flash_cmd_pkg::CODE_CONFIRM) |=> state_reg == ST_ERASE_SUSP && status_word[6])
        else $error("suspend left without resume");

endmodule : flash_command_decoder

`default_nettype wire

// [shared/flash_cmd_pkg.sv]
package flash_cmd_pkg;

    // ************************************************************
    // Bus widths
    // ************************************************************
    localparam int ADDR_W  = 24;              // Host word address width
    localparam int DATA_W  = 16;              // Host data width
    localparam int CMD_W   = 8;               // Command codes use the low byte
    localparam int COUNT_W = 5;               // Word count field, N - 1
    localparam int DEPTH   = 2;               // Entries in the operation buffer

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [7:0] CODE_READ_ARRAY   = 8'hff;
    localparam logic [7:0] CODE_READ_STATUS  = 8'h70;
    localparam logic [7:0] CODE_READ_QUERY   = 8'h98;
    localparam logic [7:0] CODE_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CODE_WORD_PROG    = 8'h40;
    localparam logic [7:0] CODE_WORD_PROG_ALT = 8'h10;
    localparam logic [7:0] CODE_BUF_PROG     = 8'he8;
    localparam logic [7:0] CODE_FACTORY_PROG = 8'h80;
    localparam logic [7:0] CODE_ERASE        = 8'h20;
    localparam logic [7:0] CODE_SUSPEND      = 8'hb0;
    localparam logic [7:0] CODE_CONFIRM      = 8'hd0;

    // ************************************************************
    // Buffer capacity and status layout
    // ************************************************************
    localparam logic [4:0] BUF_MAX_M1      = 5'h1f; // 32 words, held as N - 1
    localparam logic [7:0] STATUS_RESET    = 8'h80;
    localparam int         BIT_READY       = 7;
    localparam int         BIT_ERASE_SUSP  = 6;
    localparam int         BIT_ERASE_ERR   = 5;
    localparam int         BIT_PROG_ERR    = 4;
    localparam int         BIT_PROG_SUSP   = 2;

    // Read modes seen by the read path
    typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_QUERY} read_mode_t;

    // Operations handed to the write state machine
    typedef enum logic [2:0] {
        OP_WORD, OP_BUF_WORD, OP_BUF_CONFIRM, OP_FACTORY, OP_FACTORY_WORD, OP_ERASE
    } op_kind_t;

endpackage : flash_cmd_pkg

// [test/flash_command_decoder_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module flash_command_decoder_tb_top;
    logic mclk = 0, reset_n = 0, we_valid = 0, stall = 0, we_ready, busy, done, pf, ef, op_valid, op_ready;
    logic [23:0] we_addr = 24'h0, op_addr;
    logic [15:0] we_data = 16'h0, op_data;
    logic [2:0]  op_kind;
    logic [1:0]  read_mode;
    logic [7:0]  status_word;
    logic        sreq, rreq;
    int          n_errors = 0, checks = 0, n_susp = 0, n_res = 0;
    always #2.5 mclk = !mclk; // 200 MHz
    always @(posedge mclk) begin
        n_susp <= n_susp + sreq;
        n_res  <= n_res + rreq;
    end
    flash_command_decoder uut (.mclk(mclk), .reset_n(reset_n), .we_valid(we_valid), .we_addr(we_addr),
        .we_data(we_data), .we_ready(we_ready), .wsm_busy(busy), .wsm_done(done), .wsm_prog_fail(pf),
        .wsm_erase_fail(ef), .op_valid(op_valid), .op_ready(op_ready), .op_kind(op_kind), .op_addr(op_addr),
        .op_data(op_data), .suspend_req(sreq), .resume_req(rreq), .read_mode(read_mode), .status_word(status_word));
    wsm_model far (.mclk(mclk), .reset_n(reset_n), .stall(stall), .op_valid(op_valid), .op_kind(op_kind),
        .op_data(op_data), .suspend_req(sreq), .resume_req(rreq), .op_ready(op_ready), .wsm_busy(busy),
        .wsm_done(done), .wsm_prog_fail(pf), .wsm_erase_fail(ef));
    // Compare and count
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task results;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    // One host write, held until taken; a full buffer may refuse it for a while
    task wr(input logic [23:0] a, input logic [15:0] d);
        int i;
        we_addr  <= a;
        we_data  <= d;
        we_valid <= 1'b1;
        // Ready is looked at mid-cycle, where it stands for the coming edge
        for (i = 0; i < 100; i++) begin
            @(negedge mclk);
            if (we_ready === 1'b1) break;
        end
        if (i == 100) begin n_errors++; results; end
        @(posedge mclk);
        we_valid <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : wr
    // Bounded wait for the far side to finish, then one edge for the decoder to take done
    task idle;
        int i;
        for (i = 0; i < 200 && (busy || op_valid); i++) @(negedge mclk);
        if (i == 200) begin n_errors++; results; end
        @(posedge mclk);
        #1;
    endtask : idle
    // Word program with both setup codes; second word fails, cleared only by 0x50
    task word_prog;
        logic [7:0] code [2] = '{8'h40, 8'h10};
        for (int k = 0; k < 2; k++) begin
            stall <= 1'b1;
            wr(24'h000100 + 24'(k), {8'h00, code[k]});
            wr(24'h000100 + 24'(k), k ? 16'hdead : 16'h1234);
            chk("mode", read_mode, 1);
            chk("op", {op_kind, op_addr}, {3'h0, 24'h000100 + 24'(k)});
            chk("data", op_data, k ? 16'hdead : 16'h1234);
            stall <= 1'b0;
            wr(24'h0, 16'h00ff);
            chk("mode run", read_mode, 1);
            wr(24'h0, 16'h00b0);
            wr(24'h0, 16'h0070);
            chk("psusp", status_word, 8'h84);
            wr(24'h0, 16'h00d0);
            idle;
            wr(24'h0, 16'h0070);
            chk("status", status_word, k ? 8'h90 : 8'h80);
            wr(24'h0, 16'h0050);
            chk("cleared", status_word, 8'h80);
            wr(24'h0, 16'h00ff);
            chk("array", read_mode, 0);
        end
    endtask : word_prog
    // Bad second cycle after erase setup and an oversize count both flag bits 5,4
    task seq_err;
        logic [15:0] pr [2][2] = '{'{16'h0020, 16'h00ff}, '{16'h00e8, 16'h0020}};
        for (int k = 0; k < 2; k++) begin
            wr(24'h0, pr[k][0]);
            wr(24'h0, pr[k][1]);
            chk("err", {read_mode, status_word}, {2'h1, 8'hb0});
            wr(24'h0, 16'h0050);
            chk("clr", status_word, 8'h80);
        end
    endtask : seq_err
    // Buffered program of two words fills the buffer while the far side stalls
    task buf_prog;
        stall <= 1'b1;
        wr(24'h000200, 16'h00e8);
        wr(24'h000200, 16'h0001);
        wr(24'h000200, 16'h0aaa);
        wr(24'h000201, 16'h0bbb);
        chk("full", {we_ready, op_kind, op_data}, {1'b0, 3'h1, 16'h0aaa});
        stall <= 1'b0;
        wr(24'h000200, 16'h00d0);
        idle;
        chk("buf done", status_word, 8'h80);
    endtask : buf_prog
    // Factory entry latches address and data; afterwards every write is data
    task fact_prog;
        stall <= 1'b1;
        wr(24'h000300, 16'h0080);
        wr(24'h000300, 16'h00d0);
        chk("fact", {read_mode, op_kind, op_addr}, {2'h1, 3'h3, 24'h000300});
        chk("fact data", op_data, 16'h00d0);
        wr(24'h000301, 16'h00ff);
        chk("fact word", {we_ready, op_valid, read_mode}, {1'b0, 1'b1, 2'h1});
        stall <= 1'b0;
        idle;
        chk("fact done", status_word, 8'h80);
    endtask : fact_prog
    // Erase, filtered commands, suspend held, then resume
    task erase_susp;
        stall <= 1'b1;
        wr(24'h040000, 16'h0020);
        wr(24'h040123, 16'h00d0);
        chk("erase", {read_mode, op_kind, op_addr}, {2'h1, 3'h5, 24'h040123});
        stall <= 1'b0;
        wr(24'h0, 16'h0098);
        chk("ignored", read_mode, 1);
        wr(24'h777777, 16'h00b0);
        repeat (40) @(posedge mclk);
        chk("susp", {n_susp[23:0], status_word}, {24'h3, 8'hc0});
        wr(24'h0, 16'h0098);
        chk("query", read_mode, 2);
        wr(24'h123456, 16'h00d0);
        idle;
        chk("resume", {n_res[23:0], status_word}, {24'h3, 8'h80});
        wr(24'h0, 16'h00ff);
    endtask : erase_susp
    initial begin
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        #1;
        word_prog;
        seq_err;
        buf_prog;
        fact_prog;
        erase_susp;
        results;
    end
endmodule : flash_command_decoder_tb_top
`default_nettype wire

// [test/wsm_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Write state machine stand-in
// ************************************************************
module wsm_model (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        stall,           // Holds the head entry in the buffer
    input  wire logic        op_valid,
    input  wire logic [2:0]  op_kind,
    input  wire logic [15:0] op_data,
    input  wire logic        suspend_req,
    input  wire logic        resume_req,
    output logic             op_ready,
    output logic             wsm_busy,
    output logic             wsm_done,
    output logic             wsm_prog_fail,
    output logic             wsm_erase_fail
);
    int   cnt;                                // Cycles left of the running operation
    logic susp;                               // Suspended: count frozen, ready shown
    logic fail;                               // Word data 0xdead programs badly
    assign op_ready       = !stall;
    assign wsm_busy       = (cnt != 0) && !susp;
    assign wsm_erase_fail = 1'b0;
    // Long operations start on a pop; a suspended one keeps its count
    always @(posedge mclk) begin
        wsm_done      <= 1'b0;
        wsm_prog_fail <= 1'b0;
        if (!reset_n) begin
            cnt  <= 0;
            susp <= 1'b0;
        end else begin
            if (suspend_req) susp <= 1'b1;
            if (resume_req) susp <= 1'b0;
            // Factory entry also runs a count; its done ends the factory mode
            if (op_valid && op_ready && (op_kind inside {3'h0, 3'h2, 3'h3, 3'h5})) begin
                cnt  <= 30;
                fail <= (op_kind == 3'h0) && (op_data == 16'hdead);
            end else if (cnt != 0 && !susp) begin
                cnt           <= cnt - 1;
                wsm_done      <= (cnt == 1);
                wsm_prog_fail <= (cnt == 1) && fail;
            end
        end
    end
endmodule : wsm_model
`default_nettype wire
